/* rtl/ingress_address_decode_stripe.sv */
// Contract
// - interface id is packet source and target
// - ingress and egress ids drawn from separate pools
// - each configuration node owns one 4KB window
// - config size is 4*(1+V+P+2C+E) KB
// - one perf monitor per clock domain
// - global configuration node always present
// - axi ingress decodes address into target id
// - separate axi read and write decoders
// - unmapped address gives decode error
// - ahb ingress uses one shared decoder
// - apb egress target id names sub interface
// - every apb sub interface has its region
// - striping resolved during axi address decode
// - granule 128 to 4096 bytes
// - stripe group of one, two or four
// - single member group still splits at granule
// - group members all axi or all ahb
// - axi group members share protocol properties
// - groups may differ in granule and count
// - default and remap targets may differ
// - two members: fold all kept bits
// - four members: even and odd bit folds
`timescale 1ns/100ps
module ingress_address_decode_stripe
  import ingress_decode_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // remap state vector, same clock domain
  input wire logic [REMAP_W-1:0] remap_vec_in,
  // requests: axi read, axi write, ahb
  input wire logic [NCH-1:0] req_valid_in,
  input wire req_t [NCH-1:0] req_in,
  output logic [NCH-1:0] req_ready_out,
  // packets into the network
  output logic [NCH-1:0] pkt_valid_out,
  output pkt_t [NCH-1:0] pkt_out,
  input wire logic [NCH-1:0] pkt_ready_in,
  // decode error answers back to the requester
  output logic [NCH-1:0] rsp_valid_out,
  output rsp_t [NCH-1:0] rsp_out,
  input wire logic [NCH-1:0] rsp_ready_in
);

  // every channel carries its own decoder, so axi read and write look up
  // in parallel and the ahb channel shares one decoder for both directions
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++)
    begin : g_chan
      // source id from the ingress pool, fixed per interface
      localparam ingress_id_t SRC_ID = (ch == CH_AHB) ? AHB_INGRESS_ID : AXI_INGRESS_ID;

      chan_state_t state; // channel sequencer
      chan_state_t next_state; // its next value
      addr_t cur_addr; // address of the piece being decoded
      len_t rem; // bytes still to send
      logic wr; // direction of the held request
      pkt_t pkt; // packet register toward the network
      rsp_t rsp; // error answer register

      // lookup results
      logic hit; // address inside some region
      target_sel_t sel; // target chosen by region and remap
      addr_t base; // base of the matching region
      logic [1:0] stripe_sel; // member picked by the hash
      stripe_group_t grp; // group named by the region

      // region lookup on the held address
      region_match u_match (
        .addr_in(cur_addr),
        .remap_vec_in(remap_vec_in),
        .hit_out(hit),
        .sel_out(sel),
        .base_out(base)
      );

      assign grp = STRIPE_GROUPS[sel.group];

      // member select from the address bits above the granule
      stripe_hash u_hash (
        .addr_in(cur_addr),
        .granule_in(grp.granule),
        .count_in(grp.count),
        .select_out(stripe_sel)
      );

      // kind of the matched target
      wire is_stripe = hit && (sel.kind == RK_STRIPE); // striped region
      wire is_apb = hit && (sel.kind == RK_APB); // apb sub interface
      wire is_cfg = hit && (sel.kind == RK_CONFIG); // configuration space
      wire is_single = hit && (sel.kind == RK_SINGLE); // plain target

      // configuration node index from the 4KB window number
      wire addr_t cfg_off = cur_addr - base; // offset inside config space
      wire addr_t cfg_idx = cfg_off >> CFG_WIN_SHIFT;
      // node zero is the global node, the rest follow the sizing sum
      wire cfg_ok = (cfg_idx < addr_t'(CFG_NODES)) && (cfg_idx >= addr_t'(GLOBAL_NODE_IDX));

      // granule geometry for splitting striped bursts
      wire [4:0] gran_shift = 5'(GRAN_BASE_SHIFT) + 5'(grp.granule);
      wire len_t gran_bytes = len_t'(1) << gran_shift; // granule size
      wire len_t gran_off = cur_addr[LEN_W-1:0] & (gran_bytes - len_t'(1)); // offset in granule
      wire len_t gran_room = gran_bytes - gran_off; // bytes to boundary

      // a striped piece never crosses a granule boundary, even with one member
      wire len_t chunk = (is_stripe && (rem > gran_room)) ? gran_room : rem;

      // decode succeeds only on a mapped target
      wire dec_ok = is_single || is_apb || is_stripe || (is_cfg && cfg_ok);

      // target id: egress from the pool, sub field names apb port or node
      wire egress_id_t dec_egress = is_stripe ? (grp.first_id + egress_id_t'(stripe_sel)) :
                                    is_cfg ? CFG_EGRESS_ID : sel.egress;
      wire sub_id_t dec_sub = is_apb ? sel.sub :
                              is_cfg ? cfg_idx[SUB_W-1:0] : SUB_NONE;
      wire tgt_id_t dec_tgt = '{dec_egress, dec_sub};

      // handshake terms
      wire take_req = (state == ST_IDLE) && req_valid_in[ch]; // request accepted
      wire pkt_done = (state == ST_SEND) && pkt_ready_in[ch]; // packet taken
      wire rsp_done = (state == ST_ERR) && rsp_ready_in[ch]; // error taken
      wire last_piece = (rem == len_t'(0)); // nothing left after send

      // sequencer: take, decode, send pieces or answer the error
      always_comb
      begin
        next_state = state;
        case (state)
          ST_IDLE:
          begin
            if (take_req)
            begin
              next_state = ST_DECODE;
            end
          end
          ST_DECODE:
          begin
            // an unmapped piece goes to the error answer, not the network
            next_state = dec_ok ? ST_SEND : ST_ERR;
          end
          ST_SEND:
          begin
            if (pkt_done)
            begin
              next_state = last_piece ? ST_IDLE : ST_DECODE;
            end
          end
          ST_ERR:
          begin
            if (rsp_done)
            begin
              next_state = ST_IDLE;
            end
          end
          default:
          begin
            next_state = ST_IDLE;
          end
        endcase
      end

      // state register
      always_ff @(posedge ref_clk_in or negedge rst_b_in)
      begin
        if (!rst_b_in)
        begin
          state <= ST_IDLE;
        end
        else
        begin
          state <= next_state;
        end
      end

      // held request: loaded on accept, advanced by each decoded piece
      always_ff @(posedge ref_clk_in or negedge rst_b_in)
      begin
        if (!rst_b_in)
        begin
          cur_addr <= '0;
          rem <= '0;
          wr <= 1'b0;
        end
        else if (take_req)
        begin
          cur_addr <= req_in[ch].addr;
          rem <= req_in[ch].len;
          wr <= req_in[ch].write;
        end
        else if ((state == ST_DECODE) && dec_ok)
        begin
          cur_addr <= cur_addr + addr_t'(chunk);
          rem <= rem - chunk;
        end
      end

      // packet register, filled only on a good decode
      always_ff @(posedge ref_clk_in or negedge rst_b_in)
      begin
        if (!rst_b_in)
        begin
          pkt <= '0;
        end
        else if ((state == ST_DECODE) && dec_ok)
        begin
          pkt <= '{SRC_ID, dec_tgt, cur_addr, chunk, wr};
        end
      end

      // error answer register, filled only on a failed decode
      always_ff @(posedge ref_clk_in or negedge rst_b_in)
      begin
        if (!rst_b_in)
        begin
          rsp <= '0;
        end
        else if ((state == ST_DECODE) && !dec_ok)
        begin
          rsp <= '{SRC_ID, wr, RESP_DECERR};
        end
      end

      // handshake outputs follow the state, data outputs the registers
      assign req_ready_out[ch] = (state == ST_IDLE);
      assign pkt_valid_out[ch] = (state == ST_SEND);
      assign rsp_valid_out[ch] = (state == ST_ERR);
      assign pkt_out[ch] = pkt;
      assign rsp_out[ch] = rsp;
    end
  endgenerate

endmodule

/* rtl/ingress_decode_pkg.sv */
// shared widths, types and the static address map of the ingress decoders
package ingress_decode_pkg;

  // bus and field widths
  localparam int ADDR_W = 32;
  localparam int LEN_W = 13;
  localparam int ING_ID_W = 4;
  localparam int EGR_ID_W = 6;
  localparam int SUB_W = 8;
  localparam int NCH = 3;
  localparam int NREG = 8;
  localparam int NGROUPS = 4;
  localparam int REMAP_W = 8;

  // request channels: two axi decoders and one shared ahb decoder
  localparam int CH_AXI_RD = 0;
  localparam int CH_AXI_WR = 1;
  localparam int CH_AHB = 2;

  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [LEN_W-1:0] len_t;
  typedef logic [ING_ID_W-1:0] ingress_id_t;
  typedef logic [EGR_ID_W-1:0] egress_id_t;
  typedef logic [SUB_W-1:0] sub_id_t;

  // ingress pool and egress pool are numbered independently
  localparam ingress_id_t AXI_INGRESS_ID = 4'h0;
  localparam ingress_id_t AHB_INGRESS_ID = 4'h1;
  localparam egress_id_t CFG_EGRESS_ID = 6'h3f;
  localparam sub_id_t SUB_NONE = 8'h00;

  // configuration space sizing; the 2*C term holds one clock node and one
  // perf_monitor_unit per clock domain
  localparam int VOLT_DOMAINS = 2;
  localparam int PWR_DOMAINS = 4;
  localparam int CLK_DOMAINS = 8;
  localparam int ENDPOINTS = 24;
  localparam int PERF_MONITOR_UNITS = CLK_DOMAINS;
  localparam int CFG_NODE_KB = 4;
  localparam int CFG_SPACE_KB = CFG_NODE_KB * (1 + VOLT_DOMAINS + PWR_DOMAINS + 2 * CLK_DOMAINS + ENDPOINTS);
  localparam int CFG_NODES = CFG_SPACE_KB / CFG_NODE_KB;
  localparam int CFG_WIN_SHIFT = 12;
  localparam int GLOBAL_NODE_IDX = 0;
  localparam addr_t CFG_BASE = 32'h2000_0000;
  localparam addr_t CFG_LIMIT = CFG_BASE + addr_t'(CFG_SPACE_KB * 1024 - 1);

  // stripe granule: 128 bytes shifted left by the code
  typedef enum logic [2:0] {GRAN_128, GRAN_256, GRAN_512, GRAN_1K, GRAN_2K, GRAN_4K} granule_t;
  localparam int GRAN_BASE_SHIFT = 7;
  typedef enum logic [1:0] {SG_ONE, SG_TWO, SG_FOUR} stripe_count_t;
  // a stripe group holds axi or ahb egress members only, never apb
  typedef enum logic {EGR_AXI, EGR_AHB} stripe_kind_t;
  typedef struct packed {
    stripe_count_t count;
    granule_t granule;
    stripe_kind_t kind;
    egress_id_t first_id;
  } stripe_group_t;

  // members sit on consecutive egress ids with matching protocol setup
  localparam stripe_group_t STRIPE_GROUPS [NGROUPS] = '{
    '{SG_TWO, GRAN_256, EGR_AXI, 6'h04},
    '{SG_FOUR, GRAN_4K, EGR_AXI, 6'h08},
    '{SG_ONE, GRAN_1K, EGR_AHB, 6'h0c},
    '{SG_TWO, GRAN_128, EGR_AHB, 6'h0e}
  };

  typedef enum logic [2:0] {RK_NONE, RK_SINGLE, RK_APB, RK_STRIPE, RK_CONFIG} region_kind_t;
  typedef struct packed {
    region_kind_t kind;
    egress_id_t egress;
    sub_id_t sub;
    logic [1:0] group;
  } target_sel_t;
  typedef struct packed {
    addr_t base;
    addr_t limit;
    logic remap_en;
    logic [2:0] remap_bit;
    target_sel_t dflt;
    target_sel_t alt;
  } region_t;

  localparam target_sel_t NO_TARGET = '{RK_NONE, 6'h00, 8'h00, 2'h0};

  // address map; one region per apb interface behind the apb egress
  localparam region_t REGIONS [NREG] = '{
    '{CFG_BASE, CFG_LIMIT, 1'b0, 3'h0, '{RK_CONFIG, CFG_EGRESS_ID, 8'h00, 2'h0}, NO_TARGET},
    '{32'h0000_0000, 32'h0fff_ffff, 1'b0, 3'h0, '{RK_SINGLE, 6'h01, 8'h00, 2'h0}, NO_TARGET},
    '{32'h3000_0000, 32'h3000_0fff, 1'b0, 3'h0, '{RK_APB, 6'h10, 8'h00, 2'h0}, NO_TARGET},
    '{32'h3000_1000, 32'h3000_1fff, 1'b0, 3'h0, '{RK_APB, 6'h10, 8'h01, 2'h0}, NO_TARGET},
    '{32'h3000_2000, 32'h3000_2fff, 1'b0, 3'h0, '{RK_APB, 6'h10, 8'h0f, 2'h0}, NO_TARGET},
    '{32'h4000_0000, 32'h4fff_ffff, 1'b1, 3'h0, '{RK_STRIPE, 6'h00, 8'h00, 2'h0},
      '{RK_STRIPE, 6'h00, 8'h00, 2'h3}},
    '{32'h8000_0000, 32'hbfff_ffff, 1'b1, 3'h1, '{RK_STRIPE, 6'h00, 8'h00, 2'h1},
      '{RK_STRIPE, 6'h00, 8'h00, 2'h2}},
    '{32'hc000_0000, 32'hcfff_ffff, 1'b1, 3'h2, '{RK_SINGLE, 6'h02, 8'h00, 2'h0}, NO_TARGET}
  };

  // request, packet and response carriers
  typedef struct packed {
    addr_t addr;
    len_t len;
    logic write;
  } req_t;
  typedef struct packed {
    egress_id_t egress;
    sub_id_t sub;
  } tgt_id_t;
  typedef struct packed {
    ingress_id_t src;
    tgt_id_t tgt;
    addr_t addr;
    len_t len;
    logic write;
  } pkt_t;
  typedef struct packed {
    ingress_id_t src;
    logic write;
    logic [1:0] resp;
  } rsp_t;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {ST_IDLE, ST_DECODE, ST_SEND, ST_ERR} chan_state_t;

endpackage

/* rtl/region_match.sv */
`timescale 1ns/100ps
// compares one address against every region, lowest index wins
module region_match
  import ingress_decode_pkg::*;
(
  // lookup address and remap state
  input wire addr_t addr_in,
  input wire logic [REMAP_W-1:0] remap_vec_in,
  // chosen region
  output logic hit_out,
  output target_sel_t sel_out,
  output addr_t base_out
);

  logic [NREG-1:0] in_range; // per region hit
  target_sel_t pick [NREG]; // per region target after remap

  // one comparator pair and remap choice per region
  genvar r;
  generate
    for (r = 0; r < NREG; r++)
    begin : g_region
      assign in_range[r] = (addr_in >= REGIONS[r].base) && (addr_in <= REGIONS[r].limit);
      assign pick[r] = (REGIONS[r].remap_en && remap_vec_in[REGIONS[r].remap_bit]) ?
                       REGIONS[r].alt : REGIONS[r].dflt;
    end
  endgenerate

  // priority select, walking down so the lowest index is left standing
  always_comb
  begin
    sel_out = NO_TARGET;
    base_out = '0;
    for (int i = NREG - 1; i >= 0; i--)
    begin
      if (in_range[i])
      begin
        sel_out = pick[i];
        base_out = REGIONS[i].base;
      end
    end
  end

  assign hit_out = |in_range;
endmodule

/* rtl/stripe_hash.sv */
`timescale 1ns/100ps
// folds the address above the granule into a member select
module stripe_hash
  import ingress_decode_pkg::*;
(
  // address and group shape
  input wire addr_t addr_in,
  input wire granule_t granule_in,
  input wire stripe_count_t count_in,
  // member index inside the group
  output logic [1:0] select_out
);

  localparam addr_t EVEN_BITS = 32'h5555_5555; // even bit positions
  localparam addr_t ODD_BITS = 32'haaaa_aaaa; // odd bit positions

  wire [4:0] gran_shift = 5'(GRAN_BASE_SHIFT) + 5'(granule_in); // lowest kept bit
  addr_t kept; // address with granule offset masked off

  // drop every bit below the granule
  genvar b;
  generate
    for (b = 0; b < ADDR_W; b++)
    begin : g_mask
      assign kept[b] = addr_in[b] & (5'(b) >= gran_shift);
    end
  endgenerate

  wire all_fold = ^kept;
  wire even_fold = ^(kept & EVEN_BITS);
  wire odd_fold = ^(kept & ODD_BITS);

  // one member always selects zero
  assign select_out = (count_in == SG_FOUR) ? {odd_fold, even_fold} :
                      (count_in == SG_TWO) ? {1'b0, all_fold} : 2'h0;
endmodule

/* tb/ingress_address_decode_stripe_tb_top.sv */
`timescale 1ns/100ps
// scenario bench for the ingress decoder
module ingress_address_decode_stripe_tb_top;
  import ingress_decode_pkg::*;
  logic ref_clk_in = 1'b0; // 50 MHz
  logic rst_b_in = 1'b0; // active low
  logic [REMAP_W-1:0] remap_vec = '0; // remap state
  logic [NCH-1:0] req_valid, req_ready, pkt_valid, rsp_valid, rsp_ready;
  logic [NCH-1:0] pkt_ready = '1; // network side
  logic net_slow = 1'b0; // stall the network every other cycle
  req_t [NCH-1:0] req;
  pkt_t [NCH-1:0] pkt;
  rsp_t [NCH-1:0] rsp;
  pkt_t pq [NCH][$]; // packets taken
  rsp_t rq [NCH][$]; // answers taken
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  always #10 ref_clk_in = ~ref_clk_in;
  ingress_address_decode_stripe DUT (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .remap_vec_in(remap_vec),
    .req_valid_in(req_valid), .req_in(req), .req_ready_out(req_ready), .pkt_valid_out(pkt_valid), .pkt_out(pkt),
    .pkt_ready_in(pkt_ready), .rsp_valid_out(rsp_valid), .rsp_out(rsp), .rsp_ready_in(rsp_ready));
  requester_model partner (.ref_clk_in(ref_clk_in), .req_valid_out(req_valid), .req_out(req),
    .req_ready_in(req_ready), .rsp_valid_in(rsp_valid), .rsp_ready_out(rsp_ready));
  // collect what leaves the block, stall the network when asked
  always @(posedge ref_clk_in)
  begin
    for (int c = 0; c < NCH; c++)
    begin
      if (pkt_valid[c] === 1'b1 && pkt_ready[c]) pq[c].push_back(pkt[c]);
      if (rsp_valid[c] === 1'b1 && rsp_ready[c] === 1'b1) rq[c].push_back(rsp[c]);
    end
  end
  always @(negedge ref_clk_in) pkt_ready <= net_slow ? ~pkt_ready : '1;
  // hang guard
  always @(posedge ref_clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      $display("Error at %0t: run too long", $time);
      finish_test();
    end
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one request, waiting a bounded time for its packets or answers
  task automatic run(input int ch, input addr_t a, input len_t l, input logic wr, input int np, input int nr);
    int n;
    n = 0;
    partner.send(ch, a, l, wr);
    while (!(pq[ch].size() >= np && rq[ch].size() >= nr && req_ready[ch] === 1'b1) && n < 60)
    begin
      @(posedge ref_clk_in);
      n++;
    end
    // a channel that never settles counts as a mismatch and ends the run
    if (n >= 60)
    begin
      n_mismatch++;
      $display("Error at %0t: channel %0d never settled", $time, ch);
      finish_test();
    end
    // leave on a falling edge so later input changes stay off the sampling edge
    @(negedge ref_clk_in);
  endtask
  // next packet on a channel against its expected fields
  task automatic exp_pkt(input int ch, input logic wr, input egress_id_t eg, input sub_id_t s, input addr_t a,
    input len_t l);
    pkt_t e;
    e = '{(ch == CH_AHB) ? AHB_INGRESS_ID : AXI_INGRESS_ID, '{eg, s}, a, l, wr};
    if (pq[ch].size() == 0) check(64'h0, 64'h1);
    else check(pq[ch].pop_front(), e);
  endtask
  // one error answer and nothing forwarded
  task automatic exp_err(input int ch, input logic wr);
    rsp_t e;
    e = '{(ch == CH_AHB) ? AHB_INGRESS_ID : AXI_INGRESS_ID, wr, RESP_DECERR};
    check(64'(rq[ch].size()), 64'h1);
    if (rq[ch].size() != 0) check(64'(rq[ch].pop_front()), 64'(e));
    check(64'(pq[ch].size()), 64'h0);
  endtask
  task automatic t_plain();
    addr_t apb_a [3] = '{32'h3000_0000, 32'h3000_1000, 32'h3000_2000};
    sub_id_t apb_s [3] = '{8'h00, 8'h01, 8'h0f};
    run(CH_AXI_RD, 32'h0000_1000, 13'h0004, 1'b0, 1, 0);
    exp_pkt(CH_AXI_RD, 1'b0, 6'h01, 8'h00, 32'h0000_1000, 13'h0004);
    for (int i = 0; i < 3; i++)
    begin
      run(CH_AHB, apb_a[i], 13'h0008, 1'b1, 1, 0);
      exp_pkt(CH_AHB, 1'b1, 6'h10, apb_s[i], apb_a[i], 13'h0008);
    end
    run(CH_AXI_WR, 32'h2002_e000, 13'h0004, 1'b1, 1, 0);
    exp_pkt(CH_AXI_WR, 1'b1, CFG_EGRESS_ID, 8'h2e, 32'h2002_e000, 13'h0004);
    run(CH_AXI_WR, 32'h2000_0010, 13'h0004, 1'b1, 1, 0);
    exp_pkt(CH_AXI_WR, 1'b1, CFG_EGRESS_ID, 8'h00, 32'h2000_0010, 13'h0004);
    $display("test plain decode done");
  endtask
  task automatic t_error();
    partner.slow = 3'h7;
    run(CH_AXI_WR, 32'h1000_0000, 13'h0004, 1'b1, 0, 1);
    exp_err(CH_AXI_WR, 1'b1);
    run(CH_AHB, 32'h2002_f000, 13'h0004, 1'b0, 0, 1);
    exp_err(CH_AHB, 1'b0);
    remap_vec = 8'h04;
    run(CH_AXI_RD, 32'hc000_0000, 13'h0004, 1'b0, 0, 1);
    exp_err(CH_AXI_RD, 1'b0);
    remap_vec = 8'h00;
    partner.slow = 3'h0;
    run(CH_AXI_RD, 32'hc000_0000, 13'h0004, 1'b0, 1, 0);
    exp_pkt(CH_AXI_RD, 1'b0, 6'h02, 8'h00, 32'hc000_0000, 13'h0004);
    $display("test decode error done");
  endtask
  task automatic t_stripe();
    addr_t a4 [4] = '{32'h8000_3000, 32'h8000_2000, 32'h8000_0000, 32'h8000_1000};
    egress_id_t e4 [4] = '{6'h09, 6'h08, 6'h0a, 6'h0b};
    net_slow = 1'b1;
    run(CH_AXI_RD, 32'h4000_0080, 13'h0100, 1'b0, 2, 0);
    exp_pkt(CH_AXI_RD, 1'b0, 6'h05, 8'h00, 32'h4000_0080, 13'h0080);
    exp_pkt(CH_AXI_RD, 1'b0, 6'h04, 8'h00, 32'h4000_0100, 13'h0080);
    for (int i = 0; i < 4; i++)
    begin
      run(CH_AXI_WR, a4[i], 13'h0010, 1'b1, 1, 0);
      exp_pkt(CH_AXI_WR, 1'b1, e4[i], 8'h00, a4[i], 13'h0010);
    end
    remap_vec = 8'h03;
    run(CH_AXI_RD, 32'h4000_0000, 13'h0100, 1'b0, 2, 0);
    exp_pkt(CH_AXI_RD, 1'b0, 6'h0f, 8'h00, 32'h4000_0000, 13'h0080);
    exp_pkt(CH_AXI_RD, 1'b0, 6'h0e, 8'h00, 32'h4000_0080, 13'h0080);
    run(CH_AHB, 32'h8000_0380, 13'h0100, 1'b0, 2, 0);
    exp_pkt(CH_AHB, 1'b0, 6'h0c, 8'h00, 32'h8000_0380, 13'h0080);
    exp_pkt(CH_AHB, 1'b0, 6'h0c, 8'h00, 32'h8000_0400, 13'h0080);
    remap_vec = 8'h00;
    net_slow = 1'b0;
    $display("test striping done");
  endtask
  task automatic t_parallel();
    net_slow = 1'b1;
    fork
      run(CH_AXI_RD, 32'h0000_2000, 13'h0020, 1'b0, 1, 0);
      run(CH_AXI_WR, 32'h3000_1000, 13'h0004, 1'b1, 1, 0);
    join
    exp_pkt(CH_AXI_RD, 1'b0, 6'h01, 8'h00, 32'h0000_2000, 13'h0020);
    exp_pkt(CH_AXI_WR, 1'b1, 6'h10, 8'h01, 32'h3000_1000, 13'h0004);
    net_slow = 1'b0;
    $display("test parallel channels done");
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // reset for five cycles, then the scenarios
  initial
  begin
    repeat (5) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    rst_b_in = 1'b1;
    t_plain();
    t_error();
    t_stripe();
    t_parallel();
    finish_test();
  end
endmodule

/* tb/ingress_decode_checker.sv */
`timescale 1ns/100ps
// timing and field checks on every decode channel
module ingress_decode_checker
  import ingress_decode_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // remap and requests
  input wire logic [REMAP_W-1:0] remap_vec_in,
  input wire logic [NCH-1:0] req_valid_in,
  input wire req_t [NCH-1:0] req_in,
  input wire logic [NCH-1:0] req_ready_out,
  // packets and answers
  input wire logic [NCH-1:0] pkt_valid_out,
  input wire pkt_t [NCH-1:0] pkt_out,
  input wire logic [NCH-1:0] pkt_ready_in,
  input wire logic [NCH-1:0] rsp_valid_out,
  input wire rsp_t [NCH-1:0] rsp_out,
  input wire logic [NCH-1:0] rsp_ready_in
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  // one set of checks per channel
  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    sequence take_s;
      req_valid_in[c] && req_ready_out[c];
    endsequence
    sequence answer_s;
      pkt_valid_out[c] || rsp_valid_out[c];
    endsequence
    busy_after_take_a: assert property (take_s |=> !req_ready_out[c])
      else $error("channel still ready after a request was taken");
    answer_time_a: assert property (take_s |=> !answer_s ##1 answer_s)
      else $error("answer not two cycles after the request");
    first_piece_a: assert property (take_s ##2 pkt_valid_out[c] |->
      pkt_out[c].addr == $past(req_in[c].addr, 2) && pkt_out[c].write == $past(req_in[c].write, 2))
      else $error("first packet address or direction wrong");
    pkt_stands_a: assert property (pkt_valid_out[c] && !pkt_ready_in[c] |=>
      pkt_valid_out[c] && $stable(pkt_out[c]))
      else $error("packet dropped or changed while stalled");
    rsp_stands_a: assert property (rsp_valid_out[c] && !rsp_ready_in[c] |=>
      rsp_valid_out[c] && $stable(rsp_out[c]))
      else $error("error answer dropped or changed while stalled");
    decerr_only_a: assert property (rsp_valid_out[c] |-> rsp_out[c].resp == RESP_DECERR && !pkt_valid_out[c])
      else $error("error answer code wrong or packet sent too");
    source_id_a: assert property (pkt_valid_out[c] |->
      pkt_out[c].src == (c == CH_AHB ? AHB_INGRESS_ID : AXI_INGRESS_ID))
      else $error("packet source id wrong");
    config_node_a: assert property (pkt_valid_out[c] && pkt_out[c].tgt.egress == CFG_EGRESS_ID |->
      pkt_out[c].tgt.sub == sub_id_t'(pkt_out[c].addr[19:12]))
      else $error("configuration node index wrong");
  end
endmodule
bind ingress_address_decode_stripe ingress_decode_checker chk (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
  .remap_vec_in(remap_vec_in), .req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out),
  .pkt_valid_out(pkt_valid_out), .pkt_out(pkt_out), .pkt_ready_in(pkt_ready_in), .rsp_valid_out(rsp_valid_out),
  .rsp_out(rsp_out), .rsp_ready_in(rsp_ready_in));

/* tb/requester_model.sv */
`timescale 1ns/100ps
// requester on the ingress channels: issues requests, takes error answers
module requester_model
  import ingress_decode_pkg::*;
(
  // clock
  input wire logic ref_clk_in,
  // requests
  output logic [NCH-1:0] req_valid_out,
  output req_t [NCH-1:0] req_out,
  input wire logic [NCH-1:0] req_ready_in,
  // error answers
  input wire logic [NCH-1:0] rsp_valid_in,
  output logic [NCH-1:0] rsp_ready_out
);
  logic [NCH-1:0] slow = '0; // take answers late
  int wcnt [NCH] = '{default: 0}; // stall cycles so far
  initial
  begin
    req_valid_out = '0;
    req_out = '0;
    rsp_ready_out = '1;
  end
  // hold the request until ready is seen at a rising edge, then scramble it
  task automatic send(input int ch, input addr_t a, input len_t l, input logic wr);
    int n;
    n = 0;
    @(negedge ref_clk_in);
    req_out[ch] = '{a, l, wr};
    req_valid_out[ch] = 1'b1;
    @(posedge ref_clk_in);
    while (req_ready_in[ch] !== 1'b1 && n < 100)
    begin
      @(posedge ref_clk_in);
      n++;
    end
    @(negedge ref_clk_in);
    req_valid_out[ch] = 1'b0;
    req_out[ch] = ~req_out[ch];
  endtask
  // error answers taken at once, or after three stall cycles when slow
  always @(negedge ref_clk_in)
  begin
    for (int c = 0; c < NCH; c++)
    begin
      if (rsp_valid_in[c] === 1'b1 && slow[c] && wcnt[c] < 3)
      begin
        rsp_ready_out[c] <= 1'b0;
        wcnt[c] <= wcnt[c] + 1;
      end
      else
      begin
        rsp_ready_out[c] <= rsp_valid_in[c] || !slow[c];
        wcnt[c] <= 0;
      end
    end
  end
endmodule
